// ===== hw/cmpc_pkg.sv
// Package with register map, field layout, reset values and carrier types for the comparator block
// Functional notes
// - A high-to-low comparator output transition sets the falling-edge flag.
// - A low-to-high comparator output transition sets the rising-edge flag.
// - Edge flags stay set until software clears them; hardware never clears them.
// - Rising and falling output edges both raise a comparator interrupt request.
// - Output status bit always reads the current comparator output level.
// - Enable bit at one turns the comparator on, at zero turns it off.
// - Enabled comparator with output zero drives the oscillator wake request.
// - Hysteresis settings live in the four lowest control bits, sent to analog core.
// - Negative hysteresis selects 20 mV, 10 mV, 5 mV or disabled.
// - Positive hysteresis field selects its amount independently, same choices.
// - Writable mode register selects response time and drives the analog core.
package cmpc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] CMPC_OFS_CTRL = 4'h0;
  localparam logic [3:0] CMPC_OFS_MODE = 4'h4;
  localparam logic [3:0] CMPC_OFS_STAT = 4'h8;
  localparam logic [3:0] CMPC_OFS_MASK = 4'hc;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int CMPC_CTL_NEG_LSB = 0;
  localparam int CMPC_CTL_POS_LSB = 2;
  localparam int CMPC_CTL_OUT_BIT = 6;
  localparam int CMPC_CTL_EN_BIT = 7;

  // Status and mask layout: bit 0 rising, bit 1 falling
  localparam int CMPC_ST_RISE_BIT = 0;
  localparam int CMPC_ST_FALL_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CMPC_HYST_RST = 2'h0;
  localparam logic [1:0] CMPC_MODE_RST = 2'h2;
  localparam logic [1:0] CMPC_MASK_RST = 2'h0;

  // AXI response codes
  localparam logic [1:0] CMPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMPC_RESP_SLVERR = 2'h2;

  // Hysteresis codes
  typedef enum logic [1:0] {
    CMPC_HYST_OFF = 2'b00,
    CMPC_HYST_5MV = 2'b01,
    CMPC_HYST_10MV = 2'b10,
    CMPC_HYST_20MV = 2'b11
  } cmpc_hyst_e;

  // Settings passed to the analog core
  typedef struct packed {
    logic enable;
    cmpc_hyst_e pos_hyst;
    cmpc_hyst_e neg_hyst;
    logic [1:0] resp_mode;
  } cmpc_analog_cfg_s;

endpackage

// ===== hw/cmpc_edge_sync.sv
// Two-stage synchroniser and edge detector for the comparator output
`timescale 1ns/10ps
`default_nettype none
module cmpc_edge_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Asynchronous comparator level
  input wire logic cmp_raw,
  // Synchronised level and edge pulses
  output logic level,
  output logic rise_pulse,
  output logic fall_pulse
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  // Next values; outputs look at the second and third stages only
  always_comb
  begin
    meta_d = cmp_raw;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Three stages so each edge yields exactly one pulse
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise_pulse = sync_q & ~prev_q;
  assign fall_pulse = ~sync_q & prev_q;

endmodule // cmpc_edge_sync
`default_nettype wire

// ===== hw/cmpc_top.sv
// Comparator control and status block with AXI4-Lite register slave
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cmpc_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparator core
  input wire logic cmp_out_raw,
  output cmpc_pkg::cmpc_analog_cfg_s analog_cfg,
  // Interrupt and oscillator
  output logic cmp_irq,
  output logic osc_wake_req
);

  // ----------------------------------------------------------------
  // Output synchronisation
  // ----------------------------------------------------------------
  logic cmp_output_level;
  logic rise_evt;
  logic fall_evt;

  cmpc_edge_sync u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .cmp_raw(cmp_out_raw),
    .level(cmp_output_level),
    .rise_pulse(rise_evt),
    .fall_pulse(fall_evt)
  );

  // ----------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------
  logic aw_held_q, aw_held_d;
  logic [3:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic cmp_enable_q, cmp_enable_d;
  logic [1:0] cmp_pos_hyst_sel_q, cmp_pos_hyst_sel_d;
  logic [1:0] cmp_neg_hyst_sel_q, cmp_neg_hyst_sel_d;
  logic [1:0] cmp_resp_mode_q, cmp_resp_mode_d;
  logic cmp_rise_flag_q, cmp_rise_flag_d;
  logic cmp_fall_flag_q, cmp_fall_flag_d;
  logic [1:0] irq_mask_q, irq_mask_d;

  logic wr_fire;
  logic wr_hit_ctrl;
  logic wr_hit_mode;
  logic wr_hit_stat;
  logic wr_hit_mask;
  logic wr_ok;
  logic rd_fire;
  logic rd_ok;
  logic [31:0] rd_word;

  // Word decode shared by both channels
  function automatic logic addr_known(input logic [3:0] a);
    addr_known = (a == cmpc_pkg::CMPC_OFS_CTRL) || (a == cmpc_pkg::CMPC_OFS_MODE) ||
                 (a == cmpc_pkg::CMPC_OFS_STAT) || (a == cmpc_pkg::CMPC_OFS_MASK);
  endfunction

  // Ready while the channel slot is empty and no response is pending
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;

  // Write commits once address and data are both captured
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_ok = addr_known(aw_addr_q);
  assign wr_hit_ctrl = wr_fire & (aw_addr_q == cmpc_pkg::CMPC_OFS_CTRL) & w_strb_q[0];
  assign wr_hit_mode = wr_fire & (aw_addr_q == cmpc_pkg::CMPC_OFS_MODE) & w_strb_q[0];
  assign wr_hit_stat = wr_fire & (aw_addr_q == cmpc_pkg::CMPC_OFS_STAT) & w_strb_q[0];
  assign wr_hit_mask = wr_fire & (aw_addr_q == cmpc_pkg::CMPC_OFS_MASK) & w_strb_q[0];

  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_ok = addr_known(s_axi_araddr);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Live output level is read straight from the synchroniser
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      cmpc_pkg::CMPC_OFS_CTRL:
      begin
        rd_word[cmpc_pkg::CMPC_CTL_EN_BIT] = cmp_enable_q;
        rd_word[cmpc_pkg::CMPC_CTL_OUT_BIT] = cmp_output_level;
        rd_word[cmpc_pkg::CMPC_CTL_POS_LSB +: 2] = cmp_pos_hyst_sel_q;
        rd_word[cmpc_pkg::CMPC_CTL_NEG_LSB +: 2] = cmp_neg_hyst_sel_q;
      end
      cmpc_pkg::CMPC_OFS_MODE:
        rd_word[1:0] = cmp_resp_mode_q;
      cmpc_pkg::CMPC_OFS_STAT:
      begin
        rd_word[cmpc_pkg::CMPC_ST_RISE_BIT] = cmp_rise_flag_q;
        rd_word[cmpc_pkg::CMPC_ST_FALL_BIT] = cmp_fall_flag_q;
      end
      cmpc_pkg::CMPC_OFS_MASK:
        rd_word[1:0] = irq_mask_q;
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus channel next state
  // ----------------------------------------------------------------
  always_comb
  begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_d = 1'b1;
      aw_addr_d = {s_axi_awaddr[3:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_ok ? cmpc_pkg::CMPC_RESP_OKAY : cmpc_pkg::CMPC_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (rd_fire)
    begin
      rvalid_d = 1'b1;
      rdata_d = rd_word;
      rresp_d = rd_ok ? cmpc_pkg::CMPC_RESP_OKAY : cmpc_pkg::CMPC_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  // ----------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cmp_enable_d = cmp_enable_q;
    cmp_pos_hyst_sel_d = cmp_pos_hyst_sel_q;
    cmp_neg_hyst_sel_d = cmp_neg_hyst_sel_q;
    cmp_resp_mode_d = cmp_resp_mode_q;
    irq_mask_d = irq_mask_q;
    cmp_rise_flag_d = cmp_rise_flag_q;
    cmp_fall_flag_d = cmp_fall_flag_q;
    if (wr_hit_ctrl)
    begin
      cmp_enable_d = w_data_q[cmpc_pkg::CMPC_CTL_EN_BIT];
      cmp_pos_hyst_sel_d = w_data_q[cmpc_pkg::CMPC_CTL_POS_LSB +: 2];
      cmp_neg_hyst_sel_d = w_data_q[cmpc_pkg::CMPC_CTL_NEG_LSB +: 2];
    end
    if (wr_hit_mode)
      cmp_resp_mode_d = w_data_q[1:0];
    if (wr_hit_mask)
      irq_mask_d = w_data_q[1:0];
    // Write-one-to-clear; only software clears, and a same-cycle edge wins
    if (wr_hit_stat && w_data_q[cmpc_pkg::CMPC_ST_RISE_BIT])
      cmp_rise_flag_d = 1'b0;
    if (wr_hit_stat && w_data_q[cmpc_pkg::CMPC_ST_FALL_BIT])
      cmp_fall_flag_d = 1'b0;
    if (rise_evt)
      cmp_rise_flag_d = 1'b1;
    if (fall_evt)
      cmp_fall_flag_d = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  // Channel slots and responses; reset leaves every ready high
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= cmpc_pkg::CMPC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= cmpc_pkg::CMPC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Settings and flags; a reset drops any flag caught in flight
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cmp_enable_q <= 1'b0;
      cmp_pos_hyst_sel_q <= cmpc_pkg::CMPC_HYST_RST;
      cmp_neg_hyst_sel_q <= cmpc_pkg::CMPC_HYST_RST;
      cmp_resp_mode_q <= cmpc_pkg::CMPC_MODE_RST;
      irq_mask_q <= cmpc_pkg::CMPC_MASK_RST;
      cmp_rise_flag_q <= 1'b0;
      cmp_fall_flag_q <= 1'b0;
    end
    else
    begin
      cmp_enable_q <= cmp_enable_d;
      cmp_pos_hyst_sel_q <= cmp_pos_hyst_sel_d;
      cmp_neg_hyst_sel_q <= cmp_neg_hyst_sel_d;
      cmp_resp_mode_q <= cmp_resp_mode_d;
      irq_mask_q <= irq_mask_d;
      cmp_rise_flag_q <= cmp_rise_flag_d;
      cmp_fall_flag_q <= cmp_fall_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Analog settings straight from the control and mode registers
  assign analog_cfg.enable = cmp_enable_q;
  assign analog_cfg.pos_hyst = cmpc_pkg::cmpc_hyst_e'(cmp_pos_hyst_sel_q);
  assign analog_cfg.neg_hyst = cmpc_pkg::cmpc_hyst_e'(cmp_neg_hyst_sel_q);
  assign analog_cfg.resp_mode = cmp_resp_mode_q;

  // Either edge flag, when unmasked, holds the level interrupt
  assign cmp_irq = (cmp_rise_flag_q & irq_mask_q[cmpc_pkg::CMPC_ST_RISE_BIT]) |
                   (cmp_fall_flag_q & irq_mask_q[cmpc_pkg::CMPC_ST_FALL_BIT]);

  // Wake uses the synchronised level, so it lags the pin by two clocks
  assign osc_wake_req = cmp_enable_q & ~cmp_output_level;

endmodule // cmpc_top
`default_nettype wire

// ===== bench/cmpc_cmp_model.sv
// Behavioural model of the analog comparator core feeding the block
`timescale 1ns/10ps
`default_nettype none
module cmpc_cmp_model (
  // Commanded level and settling delay in ns
  input wire logic level_cmd,
  input wire logic [5:0] delay_ns,
  // Comparator output seen by the block
  output logic cmp_out_raw
);
  // Output follows after an analog delay, so it moves between clock edges
  // One process owns the output, starting low like an idle comparator
  initial
  begin
    cmp_out_raw = 1'b0;
    forever
    begin
      @(level_cmd);
      cmp_out_raw <= #(delay_ns) level_cmd;
    end
  end
endmodule // cmpc_cmp_model
`default_nettype wire

// ===== bench/cmpc_asserts.sv
// Concurrent checks on the ports of the comparator block
`timescale 1ns/10ps
`default_nettype none
module cmpc_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Analog side and events
  input wire logic cmp_out_raw,
  input wire cmpc_pkg::cmpc_analog_cfg_s analog_cfg,
  input wire logic cmp_irq,
  input wire logic osc_wake_req
);
  // ----------------------------------------------------------------
  // Reference synchroniser
  // ----------------------------------------------------------------
  logic s1_q, s2_q, s3_q;
  // Mirrors the two-flop path, third stage marks a detected edge
  always_ff @(posedge core_clk)
  begin
    s1_q <= resetn & cmp_out_raw;
    s2_q <= resetn & s1_q;
    s3_q <= resetn & s2_q;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not returned one cycle after address");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before ready");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before ready");
  chk_wake_level: assert property (osc_wake_req == (analog_cfg.enable && !s2_q))
    else $error("wake request does not follow enable and output level");
  chk_irq_clear: assert property ($fell(cmp_irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a register write");
  chk_irq_cause: assert property ($rose(cmp_irq) |-> $rose(s_axi_bvalid)
    || $past(s2_q) != $past(s3_q))
    else $error("interrupt raised without an edge or a write");
  chk_cfg_write: assert property (!$stable(analog_cfg) |-> $rose(s_axi_bvalid))
    else $error("analog settings changed without a write");
  chk_cfg_reset: assert property ($rose(resetn) |-> !analog_cfg.enable
    && analog_cfg.resp_mode == cmpc_pkg::CMPC_MODE_RST)
    else $error("analog settings wrong after reset");
endmodule // cmpc_asserts
bind cmpc_top cmpc_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .cmp_out_raw(cmp_out_raw),
  .analog_cfg(analog_cfg), .cmp_irq(cmp_irq), .osc_wake_req(osc_wake_req));
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the comparator control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, irq, wake, raw;
  logic lvl_cmd = 1'b0;
  logic [5:0] dly = 6'h0d;
  cmpc_pkg::cmpc_analog_cfg_s cfg;
  int n_fail = 0;
  int checked = 0;
  // 25 MHz core clock
  always #20 core_clk = ~core_clk;
  cmpc_top u_dut (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_out_raw(raw), .analog_cfg(cfg), .cmp_irq(irq),
    .osc_wake_req(wake));
  cmpc_cmp_model u_model (.level_cmd(lvl_cmd), .delay_ns(dly), .cmp_out_raw(raw));
  // ----------------------------------------------------------------
  // Report and bus tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hang();
    chk("bus answer", 32'h1, 32'h0);
    results();
  endtask
  // Ready is looked at on the falling edge, so the decision never races the design
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    logic aw_t, w_t;
    int i;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge core_clk);
      if (bvalid === 1'b1)
        break;
      aw_t = awready;
      w_t = wready;
      @(posedge core_clk);
      if (aw_t === 1'b1)
        awvalid <= 1'b0;
      if (w_t === 1'b1)
        wvalid <= 1'b0;
    end
    if (i == 40)
      hang();
    chk("write response", 32'h0, {30'h0, bresp});
    @(posedge core_clk);
    bready <= 1'b0;
  endtask
  // Aligned offsets answer OKAY; a misaligned read address is refused
  function automatic logic [1:0] exp_rresp(input logic [3:0] a);
    exp_rresp = (a[1:0] == 2'h0) ? cmpc_pkg::CMPC_RESP_OKAY : cmpc_pkg::CMPC_RESP_SLVERR;
  endfunction
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int i;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge core_clk);
      if (rvalid === 1'b1)
        break;
      if (arready === 1'b1)
      begin
        @(posedge core_clk);
        arvalid <= 1'b0;
      end
    end
    if (i == 40)
      hang();
    d = rdata;
    chk("read response", {30'h0, exp_rresp(a)}, {30'h0, rresp});
    @(posedge core_clk);
    rready <= 1'b0;
  endtask
  // Reads status and samples the interrupt once settled
  task automatic stat(input logic [1:0] f, input logic q);
    logic [31:0] v;
    rd(cmpc_pkg::CMPC_OFS_STAT, v);
    chk("status flags", {30'h0, f}, v & 32'h3);
    @(negedge core_clk);
    chk("interrupt", {31'h0, q}, {31'h0, irq});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    logic [7:0] d;
    logic [1:0] m;
    int k;
    void'($urandom(32'h4038fa59));
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(cmpc_pkg::CMPC_OFS_CTRL, v);
    chk("control reset", 32'h0, v & 32'hcf);
    rd(cmpc_pkg::CMPC_OFS_MODE, v);
    chk("mode reset", {30'h0, cmpc_pkg::CMPC_MODE_RST}, v & 32'h3);
    rd(cmpc_pkg::CMPC_OFS_MASK, v);
    chk("mask reset", 32'h0, v & 32'h3);
    stat(2'h0, 1'b0);
    // A misaligned read is refused with an error and zero data
    rd(4'h5, v);
    chk("misaligned read", 32'h0, v);
    $display("test reset values done");
    // Every hysteresis code pair, random enable and response mode
    for (k = 0; k < 16; k++)
    begin
      d = 8'($urandom());
      d[3:0] = 4'(k);
      m = 2'($urandom());
      wr(cmpc_pkg::CMPC_OFS_CTRL, d, 4'hf);
      wr(cmpc_pkg::CMPC_OFS_MODE, {6'h0, m}, 4'hf);
      rd(cmpc_pkg::CMPC_OFS_CTRL, v);
      chk("control readback", {24'h0, d & 8'h8f}, v & 32'hcf);
      @(negedge core_clk);
      chk("analog settings", {25'h0, d[7], d[3:0], m}, {25'h0, cfg});
      chk("wake request", {31'h0, d[7]}, {31'h0, wake});
    end
    $display("test settings done");
    // Byte lane zero off leaves the register untouched
    wr(cmpc_pkg::CMPC_OFS_CTRL, 8'h85, 4'hf);
    wr(cmpc_pkg::CMPC_OFS_CTRL, 8'h00, 4'he);
    rd(cmpc_pkg::CMPC_OFS_CTRL, v);
    chk("strobe ignored", 32'h85, v & 32'hcf);
    // Rising then falling edge with interrupts masked
    lvl_cmd <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(cmpc_pkg::CMPC_OFS_CTRL, v);
    chk("output level", 32'h40, v & 32'h40);
    stat(2'h1, 1'b0);
    chk("wake off", 32'h0, {31'h0, wake});
    dly <= 6'h3f;
    lvl_cmd <= 1'b0;
    repeat (8) @(posedge core_clk);
    stat(2'h3, 1'b0);
    chk("wake on", 32'h1, {31'h0, wake});
    // Unmask, then clear one flag at a time
    wr(cmpc_pkg::CMPC_OFS_MASK, 8'h03, 4'hf);
    stat(2'h3, 1'b1);
    wr(cmpc_pkg::CMPC_OFS_STAT, 8'h01, 4'hf);
    stat(2'h2, 1'b1);
    wr(cmpc_pkg::CMPC_OFS_STAT, 8'h02, 4'hf);
    stat(2'h0, 1'b0);
    $display("test edges done");
    results();
  end
endmodule // tb_top
`default_nettype wire
